// *** src/rsp_top.v ***
// Operation
// (RULE_01) signal strength two-bit code in readout bits 7-6
// (RULE_02) method 0: counter value, two's complement, bits 7-0
// (RULE_03) method 1: bits 5-4 ok/low/high code
// (RULE_04) enabled matcher pulses match for one bit
// (RULE_05) length code selects 8, 16, 24, 32 bits
// (RULE_06) tolerance code allows zero to three mismatches
// (RULE_07) clock output ratio 32, 16, 8 or 4
// (RULE_08) host writes zero into reserved bit 7
// (RULE_09) invert bit flips outgoing received data
// (RULE_10) regulation runs unless disable bit set
// (RULE_11) periodic bit repeats regulation every 60 seconds
// (RULE_12) bandwidth change restarts regulation unless suppressed
// (RULE_13) bandwidth change restarts boosting unless suppressed
// (RULE_14) load bit picks 15 pF or 11 pF
// (RULE_15) reference bytes at consecutive addresses, up to four
// (RULE_16) reference spans byte 0 bit 7 to last
// (RULE_17) oldest bit meets byte 0 bit 7
// (RULE_18) clock pin driven only when enable bit set
// (RULE_19) match when mismatch count within tolerance
// (RULE_20) disabled matcher holds match output low
`timescale 1ns/10ps
`include "rsp_consts.vh"
`default_nettype none

module rsp_top #(
  parameter [31:0] REG_PERIOD_CYC = `RSP_REG_PERIOD_CYC // periodic regulation interval
) (
  input  wire        clock_i,           // crystal clock, 25 MHz
  input  wire        nrst_i,            // sync reset, active low
  // avalon-mm slave
  input  wire [5:0]  avs_address_i,     // byte address
  input  wire        avs_read_i,        // read request
  input  wire        avs_write_i,       // write request
  input  wire [31:0] avs_writedata_i,   // write data, low byte used
  input  wire [3:0]  avs_byteenable_i,  // byte lanes
  output reg  [31:0] avs_readdata_o,    // read data
  output reg         avs_waitrequest_o, // stall
  // receiver side pins
  input  wire        rx_bit_i,          // demodulated bit
  input  wire        rx_bit_clk_i,      // recovered bit clock
  input  wire        rx_enable_i,       // receiver enabled
  input  wire [1:0]  bw_sel_i,          // selected filter bandwidth
  input  wire [1:0]  rssi_level_i,      // signal strength code
  input  wire [7:0]  fei_count_i,       // up/down counter value
  input  wire [1:0]  fei_code_i,        // correlator verdict
  // outputs
  output reg         rx_data_o,         // received data, maybe inverted
  output wire        match_o,           // reference word seen
  output wire        clk_out_o,         // divided clock
  output reg         clk_out_oe_o,      // divided clock pin enable
  output reg         bw_regulate_o,     // start regulation pulse
  output reg         bw_boost_o,        // start boosting pulse
  output reg         osc_load_low_current_o // low-current load mode
);


  // register storage

  reg  [7:0]  link_ctrl_r;              // method select and clock enable
  reg  [7:0]  receive_options_first_r;  // match and divider options
  reg  [7:0]  receive_options_second_r; // data and regulation options
  reg  [7:0]  ref_byte_r [0:3];         // reference word bytes
  reg         ack_r;                    // bus answer phase

  wire        freq_error_method_sel;    // 0 counter, 1 verdict code
  wire        divided_clock_enable;     // clock pin enable
  wire        match_enable;             // matcher on
  wire [1:0]  match_length_sel;         // reference length code
  wire [1:0]  match_error_tolerance;    // tolerated mismatches
  wire [1:0]  clock_out_divider_sel;    // divider ratio code
  wire        rx_data_invert;           // flip outgoing data
  wire        bw_regulation_disable;    // suppress regulation
  wire        bw_regulation_periodic;   // repeat every interval
  wire        bw_change_no_regulation;  // no regulation on bw change
  wire        bw_change_no_boost;       // no boost on bw change
  wire        osc_load_low_current;     // 11 pF mode

  assign freq_error_method_sel   = link_ctrl_r[`RSP_BIT_FEI_METHOD];
  assign divided_clock_enable    = link_ctrl_r[`RSP_BIT_CLKOUT_EN];
  assign match_enable            = receive_options_first_r[`RSP_BIT_MATCH_EN];
  assign match_length_sel        = receive_options_first_r[`RSP_LEN_MSB:`RSP_LEN_LSB];
  assign match_error_tolerance   = receive_options_first_r[`RSP_TOL_MSB:`RSP_TOL_LSB];
  assign clock_out_divider_sel   = receive_options_first_r[`RSP_DIV_MSB:`RSP_DIV_LSB];
  assign rx_data_invert          = receive_options_second_r[`RSP_BIT_INVERT];
  assign bw_regulation_disable   = receive_options_second_r[`RSP_BIT_REG_DIS];
  assign bw_regulation_periodic  = receive_options_second_r[`RSP_BIT_REG_PERIOD];
  assign bw_change_no_regulation = receive_options_second_r[`RSP_BIT_BW_NO_REG];
  assign bw_change_no_boost      = receive_options_second_r[`RSP_BIT_BW_NO_BOOST];
  assign osc_load_low_current    = receive_options_second_r[`RSP_BIT_OSC_LOW];


  // pin synchronisers: every pin input passes two flops

  localparam SW = 17; // synchronised pin bits

  wire [SW-1:0] pins_raw; // pins as they arrive
  reg  [SW-1:0] sync1_r;  // first stage, read only by sync2_r
  reg  [SW-1:0] sync2_r;  // second stage, safe to use
  reg           bclk_d_r; // previous bit clock for edge detect

  assign pins_raw = {rx_bit_i, rx_bit_clk_i, rx_enable_i, bw_sel_i,
                     rssi_level_i, fei_count_i, fei_code_i};

  wire       s_bit   = sync2_r[16]; // received bit
  wire       s_bclk  = sync2_r[15]; // bit clock
  wire       s_rxen  = sync2_r[14]; // receiver enabled
  wire [1:0] s_bw    = sync2_r[13:12]; // bandwidth select
  wire [1:0] s_rssi  = sync2_r[11:10]; // signal strength
  wire [7:0] s_fei   = sync2_r[9:2];   // counter value
  wire [1:0] s_fcode = sync2_r[1:0];   // verdict code
  wire       bit_tick = s_bclk & ~bclk_d_r; // one pulse per bit

  // the counter bus is sampled bit by bit; a value caught mid-change
  // may be off for one sample, acceptable for a slow readout
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      sync1_r  <= {SW{1'b0}};
      sync2_r  <= {SW{1'b0}};
      bclk_d_r <= 1'b0;
    end else begin
      sync1_r  <= pins_raw;
      sync2_r  <= sync1_r;
      bclk_d_r <= s_bclk;
    end
  end


  // readout byte

  reg [7:0] readout; // live signal quality byte

  // method 0 gives the full counter byte; method 1 packs strength
  // and the verdict code, lower nibble zero
  always @* begin
    if (!freq_error_method_sel) begin
      readout = s_fei; // [RULE_02]
    end else begin
      readout = 8'h00;
      readout[`RSP_RSSI_MSB:`RSP_RSSI_LSB]       = s_rssi;  // [RULE_01]
      readout[`RSP_FEI_CODE_MSB:`RSP_FEI_CODE_LSB] = s_fcode; // [RULE_03]
    end
  end


  // avalon-mm slave

  wire [3:0] idx     = avs_address_i[5:2];   // register index
  wire       aligned = (avs_address_i[1:0] == 2'b00); // word aligned
  wire       req     = avs_read_i | avs_write_i;      // any request
  wire       wr_go   = ack_r & avs_write_i & aligned & avs_byteenable_i[0];
  wire [7:0] wbyte   = avs_writedata_i[7:0]; // data lane 0

  reg  [7:0] rbyte;   // decoded read byte

  // unmapped or misaligned reads answer zero
  always @* begin
    rbyte = 8'h00;
    if (aligned) begin
      case (idx)
        `RSP_IDX_LINK_CTRL:   rbyte = link_ctrl_r;
        `RSP_IDX_READOUT:     rbyte = readout;
        `RSP_IDX_OPTS_FIRST:  rbyte = receive_options_first_r;
        `RSP_IDX_OPTS_SECOND: rbyte = receive_options_second_r;
        `RSP_IDX_REF_BYTE0:   rbyte = ref_byte_r[0]; // [RULE_15]
        `RSP_IDX_REF_BYTE1:   rbyte = ref_byte_r[1];
        `RSP_IDX_REF_BYTE2:   rbyte = ref_byte_r[2];
        `RSP_IDX_REF_BYTE3:   rbyte = ref_byte_r[3];
        default:              rbyte = 8'h00;
      endcase
    end
  end

  // fixed one-stall answer: waitrequest drops in the cycle after the
  // request appears, the transfer completes on that edge
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      ack_r             <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end else if (ack_r) begin
      // completing edge: release and rearm
      ack_r             <= 1'b0;
      avs_waitrequest_o <= 1'b1;
    end else if (req) begin
      ack_r             <= 1'b1;
      avs_waitrequest_o <= 1'b0;
      avs_readdata_o    <= {24'h000000, rbyte};
    end
  end

  // register writes; reserved bits of the second option byte are not
  // stored, so they read zero whatever the host writes
  integer k;
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      link_ctrl_r              <= `RSP_RST_BYTE;
      receive_options_first_r  <= `RSP_RST_BYTE;
      receive_options_second_r <= `RSP_RST_BYTE;
      for (k = 0; k < 4; k = k + 1) begin
        ref_byte_r[k] <= `RSP_RST_BYTE;
      end
    end else if (wr_go) begin
      case (idx)
        `RSP_IDX_LINK_CTRL:   link_ctrl_r <= wbyte;
        `RSP_IDX_OPTS_FIRST:  receive_options_first_r <= wbyte;
        `RSP_IDX_OPTS_SECOND: receive_options_second_r <= wbyte & `RSP_OPTS2_RW_MASK; // [RULE_08]
        `RSP_IDX_REF_BYTE0:   ref_byte_r[0] <= wbyte; // [RULE_15]
        `RSP_IDX_REF_BYTE1:   ref_byte_r[1] <= wbyte;
        `RSP_IDX_REF_BYTE2:   ref_byte_r[2] <= wbyte;
        `RSP_IDX_REF_BYTE3:   ref_byte_r[3] <= wbyte;
        default:              link_ctrl_r <= link_ctrl_r;
      endcase
    end
  end


  // received data path and static outputs

  always @(posedge clock_i) begin
    if (!nrst_i) begin
      rx_data_o              <= 1'b0;
      clk_out_oe_o           <= 1'b0;
      osc_load_low_current_o <= 1'b0;
    end else begin
      rx_data_o              <= s_bit ^ rx_data_invert;  // [RULE_09]
      clk_out_oe_o           <= divided_clock_enable;    // [RULE_18]
      osc_load_low_current_o <= osc_load_low_current;    // [RULE_14]
    end
  end


  // bandwidth regulation and boost sequencing

  reg        rxen_d_r;   // previous receiver enable
  reg  [1:0] bw_d_r;     // previous bandwidth select
  reg  [31:0] period_r;  // periodic interval counter
  wire       rx_start  = s_rxen & ~rxen_d_r;         // receiver start
  wire       bw_change = s_rxen & (s_bw != bw_d_r);  // bandwidth moved
  wire       period_hit = (period_r == REG_PERIOD_CYC - 32'h1);

  // all regulation triggers are gated by the disable bit, the boost trigger is not; periodic and bw-change also by their own bit
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      rxen_d_r      <= 1'b0;
      bw_d_r        <= 2'b00;
      period_r      <= 32'h00000000;
      bw_regulate_o <= 1'b0;
      bw_boost_o    <= 1'b0;
    end else begin
      rxen_d_r <= s_rxen;
      bw_d_r   <= s_bw;
      // interval restarts with the receiver and whenever not periodic
      if (!s_rxen || !bw_regulation_periodic || rx_start || period_hit) begin
        period_r <= 32'h00000000;
      end else begin
        period_r <= period_r + 32'h1; // [RULE_11]
      end
      bw_regulate_o <= ~bw_regulation_disable &                 // [RULE_10]
                       (rx_start |                               // [RULE_11]
                        (bw_regulation_periodic & s_rxen & period_hit) |
                        (bw_change & ~bw_change_no_regulation)); // [RULE_12]
      bw_boost_o    <= bw_change & ~bw_change_no_boost;          // [RULE_13]
    end
  end


  // sub-blocks

  rsp_pattern_match u_match (
    .clock_i    (clock_i),
    .nrst_i     (nrst_i),
    .bit_tick_i (bit_tick),
    .bit_i      (s_bit),
    .enable_i   (match_enable),
    .len_sel_i  (match_length_sel),
    .tol_i      (match_error_tolerance),
    .ref_i      ({ref_byte_r[0], ref_byte_r[1], ref_byte_r[2], ref_byte_r[3]}),
    .match_o    (match_o)
  );

  rsp_clk_div u_div (
    .clock_i   (clock_i),
    .nrst_i    (nrst_i),
    .enable_i  (divided_clock_enable),
    .sel_i     (clock_out_divider_sel),
    .clk_out_o (clk_out_o)
  );

endmodule

`default_nettype wire

// *** include/rsp_consts.vh ***
`ifndef RSP_CONSTS_VH
`define RSP_CONSTS_VH

// register indices; byte address on the bus is four times the index
`define RSP_IDX_LINK_CTRL   4'h1
`define RSP_IDX_READOUT     4'h5
`define RSP_IDX_OPTS_FIRST  4'h6
`define RSP_IDX_OPTS_SECOND 4'h7
`define RSP_IDX_REF_BYTE0   4'h8
`define RSP_IDX_REF_BYTE1   4'h9
`define RSP_IDX_REF_BYTE2   4'ha
`define RSP_IDX_REF_BYTE3   4'hb

// link control fields (index 0x1)
`define RSP_BIT_FEI_METHOD  4
`define RSP_BIT_CLKOUT_EN   0

// readout fields (index 0x5)
`define RSP_RSSI_MSB        7
`define RSP_RSSI_LSB        6
`define RSP_FEI_CODE_MSB    5
`define RSP_FEI_CODE_LSB    4

// first option byte fields (index 0x6)
`define RSP_BIT_MATCH_EN    7
`define RSP_LEN_MSB         6
`define RSP_LEN_LSB         5
`define RSP_TOL_MSB         4
`define RSP_TOL_LSB         3
`define RSP_DIV_MSB         2
`define RSP_DIV_LSB         1

// second option byte fields (index 0x7)
`define RSP_BIT_RESERVED7   7
`define RSP_BIT_INVERT      6
`define RSP_BIT_REG_DIS     5
`define RSP_BIT_REG_PERIOD  4
`define RSP_BIT_BW_NO_REG   3
`define RSP_BIT_BW_NO_BOOST 2
`define RSP_BIT_OSC_LOW     1
`define RSP_OPTS2_RW_MASK   8'h7e

// reset values
`define RSP_RST_BYTE        8'h00

// timing: periodic regulation interval and clock rate
`define RSP_REG_PERIOD_S    60
`define RSP_CLK_HZ          25000000
`define RSP_REG_PERIOD_CYC  (`RSP_REG_PERIOD_S * `RSP_CLK_HZ)

`endif

// *** src/rsp_clk_div.v ***
`timescale 1ns/10ps
`default_nettype none

// divided clock for the clock output pin, ratio 32, 16, 8 or 4
module rsp_clk_div (
  input  wire       clock_i,  // crystal clock
  input  wire       nrst_i,   // sync reset, active low
  input  wire       enable_i, // divided clock enabled
  input  wire [1:0] sel_i,    // ratio select
  output reg        clk_out_o // registered divided clock
);

  reg  [4:0] cnt_r;   // free-running prescaler
  wire [4:0] cnt_nxt; // next prescaler value

  assign cnt_nxt = cnt_r + 5'h01;

  // code 00 taps bit 4 (div 32), 11 taps bit 1 (div 4)
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      cnt_r     <= 5'h00;
      clk_out_o <= 1'b0;
    end else if (!enable_i) begin
      // parked low so the pin restarts with a clean phase
      cnt_r     <= 5'h00;
      clk_out_o <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      clk_out_o <= cnt_nxt[3'd4 - {1'b0, sel_i}]; // [RULE_07]
    end
  end

endmodule

`default_nettype wire

// *** src/rsp_pattern_match.v ***
`timescale 1ns/10ps
`default_nettype none

// sliding-window reference word matcher with error tolerance
module rsp_pattern_match (
  input  wire        clock_i,   // system clock
  input  wire        nrst_i,    // sync reset, active low
  input  wire        bit_tick_i,// one pulse per received bit
  input  wire        bit_i,     // received bit, valid with tick
  input  wire        enable_i,  // matching enabled
  input  wire [1:0]  len_sel_i, // 8/16/24/32 bits
  input  wire [1:0]  tol_i,     // tolerated mismatches
  input  wire [31:0] ref_i,     // bytes 0..3, byte 0 in [31:24]
  output reg         match_o    // high for one bit period
);

  reg  [31:0] window_r;  // newest bit in bit 0
  reg         cmp_r;     // compare one cycle after the shift
  reg  [31:0] ref_al;    // reference aligned to window low bits
  reg  [31:0] mask;      // bits in use for the length
  wire [31:0] diff;      // masked mismatches
  wire [5:0]  sum [0:32];// running mismatch count

  // byte 0 bit 7 lines up with the oldest bit in the window
  always @* begin
    case (len_sel_i)
      2'b00: begin
        ref_al = {24'h000000, ref_i[31:24]};
        mask   = 32'h000000ff;
      end
      2'b01: begin
        ref_al = {16'h0000, ref_i[31:16]};
        mask   = 32'h0000ffff;
      end
      2'b10: begin
        ref_al = {8'h00, ref_i[31:8]};
        mask   = 32'h00ffffff;
      end
      default: begin
        ref_al = ref_i;
        mask   = 32'hffffffff;
      end
    endcase
  end

  assign diff   = (window_r ^ ref_al) & mask; // [RULE_17] [RULE_05] [RULE_16]
  assign sum[0] = 6'h00;

  // one adder stage per window bit
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : g_cnt
      assign sum[g+1] = sum[g] + {5'h00, diff[g]}; // [RULE_19]
    end
  endgenerate

  // shift on each bit, decide one cycle later, hold until the next decision
  always @(posedge clock_i) begin
    if (!nrst_i) begin
      window_r <= 32'h00000000;
      cmp_r    <= 1'b0;
      match_o  <= 1'b0;
    end else begin
      cmp_r <= bit_tick_i;
      if (bit_tick_i) begin
        window_r <= {window_r[30:0], bit_i};
      end
      if (!enable_i) begin
        match_o <= 1'b0; // [RULE_20]
      end else if (cmp_r) begin
        match_o <= (sum[32] <= {4'h0, tol_i}); // [RULE_04] [RULE_06] [RULE_19]
      end
    end
  end

endmodule

`default_nettype wire

// *** verif/rsp_top_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
// handshake, pulse and gating checks seen from the top ports
module rsp_top_sva (
  input wire logic        clock_i,           // crystal clock
  input wire logic        nrst_i,            // sync reset, active low
  input wire logic [5:0]  avs_address_i,     // byte address
  input wire logic        avs_read_i,        // read request
  input wire logic        avs_write_i,       // write request
  input wire logic [31:0] avs_writedata_i,   // write data
  input wire logic [3:0]  avs_byteenable_i,  // byte lanes
  input wire logic [31:0] avs_readdata_o,    // read data
  input wire logic        avs_waitrequest_o, // stall
  input wire logic        rx_bit_clk_i,      // recovered bit clock
  input wire logic        match_o,           // reference word seen
  input wire logic        clk_out_o,         // divided clock
  input wire logic        clk_out_oe_o,      // divided clock pin enable
  input wire logic        bw_regulate_o      // regulation pulse
);
  logic       en_r;    // shadow of the match enable bit
  logic       bclk_r;  // bit clock one cycle ago
  logic [3:0] since_r; // cycles since the bit clock rose, saturating
  wire        en_wr;   // accepted write to the first option byte
  assign en_wr = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
                 && avs_address_i == 6'h18;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // shadow follows the register, which is written at the ack edge
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      en_r    <= 1'b0;
      bclk_r  <= 1'b0;
      since_r <= 4'hf;
    end else begin
      bclk_r <= rx_bit_clk_i;
      if (en_wr) begin
        en_r <= avs_writedata_i[7];
      end
      // restart on a rising bit clock, else count up to the ceiling
      if (rx_bit_clk_i && !bclk_r) begin
        since_r <= 4'h0;
      end else if (since_r != 4'hf) begin
        since_r <= since_r + 4'h1;
      end
    end
  end
  property p_ack; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o; endproperty
  a_ack: assert property (p_ack) else $error("request not answered next cycle");
  property p_ack_one; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_idle; !avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_idle: assert property (p_idle) else $error("ack without request");
  property p_unmap; avs_read_i && !avs_waitrequest_o && avs_address_i[5:4] == 2'b11
    |-> avs_readdata_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_clk_off; !clk_out_oe_o |-> !clk_out_o; endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock pin active while off");
  property p_no_match; !en_r && !$past(en_r) |-> !match_o; endproperty
  a_no_match: assert property (p_no_match) else $error("match while disabled");
  property p_match_bit; $rose(match_o) |-> since_r >= 4'h2 && since_r <= 4'h8; endproperty
  a_match_bit: assert property (p_match_bit) else $error("match not tied to a bit");
  property p_reg_pulse; bw_regulate_o |=> !bw_regulate_o; endproperty
  a_reg_pulse: assert property (p_reg_pulse) else $error("regulation pulse too long");
endmodule
bind rsp_top rsp_top_sva chk (
  .clock_i(clock_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .rx_bit_clk_i(rx_bit_clk_i), .match_o(match_o),
  .clk_out_o(clk_out_o), .clk_out_oe_o(clk_out_oe_o), .bw_regulate_o(bw_regulate_o));
`default_nettype wire

// *** verif/rsp_demod_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// demodulator side: bits leave oldest first, clock rises mid-bit
module rsp_demod_model #(
  parameter int HALF = 8 // half bit period in clock cycles
) (
  input  wire logic clock_i,  // system clock
  output var  logic bit_o,    // demodulated bit
  output var  logic bit_clk_o // recovered bit clock
);
  initial begin
    bit_o = 1'b0;
    bit_clk_o = 1'b0;
  end
  // send n low bits of w; the clock stands low between frames
  task automatic send(input logic [32:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clock_i);
      bit_o <= w[i];
      repeat (HALF) @(posedge clock_i);
      bit_clk_o <= 1'b1;
      repeat (HALF - 1) @(posedge clock_i);
      bit_clk_o <= 1'b0;
    end
    @(posedge clock_i);
    bit_o <= ~bit_o; // a released line must not keep its last value
  endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin \
  compares++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("unexpected at %0t: mismatch on line %0d", $time, `__LINE__); \
  end \
end
module tb;
  logic        clock_i = 1'b0;  // 25 MHz clock
  logic        nrst_i = 1'b0;   // sync reset, active low
  logic [5:0]  address = 6'h0;  // bus address
  logic        read = 1'b0;     // bus read
  logic        write = 1'b0;    // bus write
  logic [31:0] wdata = 32'h0;   // bus write data
  logic [3:0]  be = 4'h0;       // byte lanes
  logic        rx_en = 1'b0;    // receiver enabled
  logic [1:0]  bw_sel = 2'h0;   // selected bandwidth
  logic [1:0]  rssi = 2'h0;     // strength code
  logic [7:0]  fei_cnt = 8'h0;  // counter value
  logic [1:0]  fei_code = 2'h0; // correlator verdict
  logic [31:0] q, rdata;        // read data
  logic        waitreq, rx_bit, rx_bclk, rx_data, match, clk_out, oe, reg_p, boost_p, osc;
  int          num_errors = 0, compares = 0, reg_cnt = 0, boost_cnt = 0, hi_cnt = 0;
  rsp_demod_model #(.HALF(8)) far (.clock_i(clock_i), .bit_o(rx_bit), .bit_clk_o(rx_bclk));
  rsp_top #(.REG_PERIOD_CYC(32'd50)) dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .avs_address_i(address), .avs_read_i(read),
    .avs_write_i(write), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .rx_bit_i(rx_bit),
    .rx_bit_clk_i(rx_bclk), .rx_enable_i(rx_en), .bw_sel_i(bw_sel), .rssi_level_i(rssi),
    .fei_count_i(fei_cnt), .fei_code_i(fei_code), .rx_data_o(rx_data), .match_o(match),
    .clk_out_o(clk_out), .clk_out_oe_o(oe), .bw_regulate_o(reg_p), .bw_boost_o(boost_p),
    .osc_load_low_current_o(osc));
  always #20 clock_i = ~clock_i;
  // pulse and match-high tallies, read as differences by the scenarios
  always @(posedge clock_i) begin
    reg_cnt <= reg_cnt + int'(reg_p);
    boost_cnt <= boost_cnt + int'(boost_p);
    hi_cnt <= hi_cnt + int'(match);
  end
  // one transfer: the request stands until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d,
                     input logic [3:0] b, output logic [31:0] rd);
    int t;
    t = 0;
    address <= a;
    wdata <= {24'h0, d};
    be <= b;
    read <= ~wr;
    write <= wr;
    @(posedge clock_i);
    while (waitreq !== 1'b0 && t < 100) begin
      @(posedge clock_i);
      t++;
    end
    `CHK(t < 100, 1'b1)
    rd = rdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 16; i++) begin
      bus(1'b0, 6'(4 * i), 8'h00, 4'h1, q);
      `CHK(q, 32'h0)
    end
    bus(1'b1, 6'h1c, 8'h7f, 4'h1, q); // unused bit 0 kept zero
    bus(1'b0, 6'h1c, 8'h00, 4'h1, q);
    `CHK(q, 32'h7e)
    bus(1'b1, 6'h24, 8'h5a, 4'h1, q);
    bus(1'b1, 6'h24, 8'hff, 4'h0, q); // no lane, ignored
    bus(1'b1, 6'h30, 8'hff, 4'h1, q); // unmapped, ignored
    bus(1'b1, 6'h25, 8'hff, 4'h1, q); // misaligned, ignored
    bus(1'b0, 6'h24, 8'h00, 4'h1, q);
    `CHK(q, 32'h5a)
    bus(1'b0, 6'h30, 8'h00, 4'h1, q);
    `CHK(q, 32'h0)
    bus(1'b0, 6'h25, 8'h00, 4'h1, q);
    `CHK(q, 32'h0)
    bus(1'b1, 6'h1c, 8'h00, 4'h1, q);
  endtask
  task automatic t_readout;
    logic [1:0] c;
    fei_cnt <= 8'h9c;
    bus(1'b1, 6'h04, 8'h00, 4'h1, q);
    bus(1'b0, 6'h14, 8'h00, 4'h1, q);
    `CHK(q, 32'h9c)
    bus(1'b1, 6'h04, 8'h10, 4'h1, q);
    for (int i = 0; i < 12; i++) begin
      c = {i[3:2] != 2'b00, i[3]};
      rssi <= i[1:0];
      fei_code <= c;
      repeat (4) @(posedge clock_i);
      bus(1'b0, 6'h14, 8'h00, 4'h1, q);
      `CHK(q, {24'h0, i[1:0], c, 4'h0})
    end
  endtask
  task automatic t_inv;
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 6'h1c, {1'b0, k[1], 4'h0, k[0], 1'b0}, 4'h1, q);
      far.send({32'h0, k[0]}, 1);
      repeat (4) @(posedge clock_i);
      `CHK(rx_data, ~k[0] ^ k[1])
      `CHK(osc, k[0])
    end
    bus(1'b1, 6'h1c, 8'h00, 4'h1, q);
  endtask
  // full divided period measured from one rise to the next
  task automatic per(output int n);
    int g;
    n = 0;
    g = 0;
    for (int k = 0; k < 4; k++) begin
      while (clk_out !== k[0] && g < 300) begin
        @(posedge clock_i);
        g++;
        n += int'(k > 1);
      end
    end
  endtask
  task automatic t_clk;
    int n;
    bus(1'b1, 6'h04, 8'h00, 4'h1, q);
    repeat (4) @(posedge clock_i);
    `CHK({oe, clk_out}, 2'b00)
    bus(1'b1, 6'h04, 8'h01, 4'h1, q);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 6'h18, {5'h0, s[1:0], 1'b0}, 4'h1, q);
      per(n);
      per(n);
      `CHK(n, 32 >> s)
      `CHK(oe, 1'b1)
    end
    bus(1'b1, 6'h04, 8'h00, 4'h1, q);
  endtask
  task automatic pulses(input int c, input int er, input int eb);
    int r;
    int b;
    r = reg_cnt;
    b = boost_cnt;
    repeat (c) @(posedge clock_i);
    `CHK(reg_cnt - r, er)
    `CHK(boost_cnt - b, eb)
  endtask
  task automatic t_regul;
    rx_en <= 1'b1;
    pulses(10, 1, 0);
    bw_sel <= 2'h1;
    pulses(10, 1, 1);
    bus(1'b1, 6'h1c, 8'h10, 4'h1, q);
    repeat (60) @(posedge clock_i);
    pulses(100, 2, 0);
    bus(1'b1, 6'h1c, 8'h00, 4'h1, q);
    repeat (5) @(posedge clock_i);
    pulses(100, 0, 0);
    bus(1'b1, 6'h1c, 8'h20, 4'h1, q);
    bw_sel <= 2'h2;
    pulses(10, 0, 1);
    bus(1'b1, 6'h1c, 8'h0c, 4'h1, q);
    bw_sel <= 2'h3;
    pulses(10, 0, 0);
    bus(1'b1, 6'h1c, 8'h20, 4'h1, q);
    rx_en <= 1'b0;
    repeat (5) @(posedge clock_i);
    rx_en <= 1'b1;
    pulses(10, 0, 0);
    rx_en <= 1'b0;
    bus(1'b1, 6'h1c, 8'h00, 4'h1, q);
  endtask
  // each length with errors at the tolerance and one beyond it
  task automatic t_match;
    logic [31:0] rw;
    logic [31:0] w;
    int h;
    rw = 32'hb46e1d93;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 6'(32 + 4 * i), rw[31 - 8 * i -: 8], 4'h1, q);
    end
    for (int l = 0; l < 4; l++) begin
      for (int e = l; e < l + 2; e++) begin
        bus(1'b1, 6'h18, {1'b1, l[1:0], l[1:0], 3'h0}, 4'h1, q);
        w = (rw >> (24 - 8 * l)) ^ ((32'h1 << e) - 32'h1);
        h = hi_cnt;
        far.send({w, ~w[0]}, 9 + 8 * l);
        repeat (8) @(posedge clock_i);
        `CHK(hi_cnt - h, (e == l) ? 16 : 0)
      end
    end
    bus(1'b1, 6'h18, 8'h00, 4'h1, q);
    h = hi_cnt;
    far.send({rw[31:24], ~rw[24]}, 9);
    repeat (8) @(posedge clock_i);
    `CHK(hi_cnt - h, 0)
  endtask
  task automatic end_sim;
    if (num_errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    t_regs;
    t_readout;
    t_inv;
    t_clk;
    t_regul;
    t_match;
    end_sim;
  end
  // the whole run needs well under ten thousand cycles
  initial begin
    repeat (40000) @(posedge clock_i);
    num_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
